// >>> shared/wakeup_timer_pkg.sv
package wakeup_timer_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LV_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TRIM = 8'h08;
  localparam logic [7:0] ADDR_RATE_HI = 8'h0C;
  localparam logic [7:0] ADDR_RATE_LO = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LV_STATUS_BIT = 2;
  localparam int LV_IE_BIT = 1;
  localparam int LV_FLAG_BIT = 0;
  localparam int PT_CLKSEL_BIT = 7;
  localparam int PT_WAVESEL_BIT = 4;
  localparam int PT_PINEN_BIT = 3;
  localparam int PT_FE_BIT = 2;
  localparam int PT_IE_BIT = 1;
  localparam int PT_FLAG_BIT = 0;
  localparam int IRQ_LV_BIT = 0;
  localparam int IRQ_PT_BIT = 1;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // slow clock period in bus clocks (stand-in for the slow oscillator)
  localparam int SLOW_DIV_DEFAULT = 16;
  // half of the minimum period, in timer half-period ticks
  localparam int PULSE_TICKS = 1;

endpackage : wakeup_timer_pkg

// >>> hw/slow_tick_gen.sv
`timescale 1ns/100ps
module slow_tick_gen
  import wakeup_timer_pkg::*;
#(
  parameter int DIV = SLOW_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic signed [5:0] trim,
  output logic tick
);
  // ----------------------------------------------------------------
  // trimmed slow clock: higher trim, shorter period
  // ----------------------------------------------------------------
  logic [15:0] cnt_reg;
  logic [15:0] limit;

  always_comb begin
    limit = 16'(DIV) - 16'($signed({{10{trim[5]}}, trim}) >>> 2);
    if (limit < 16'h0004) begin
      limit = 16'h0004;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_reg >= limit - 16'h0001) begin
      cnt_reg <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : slow_tick_gen

// >>> hw/period_counter.sv
`timescale 1ns/100ps
module period_counter
  import wakeup_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic step,
  input wire logic [15:0] rate,
  output logic half_tick,
  output logic expire
);
  // ----------------------------------------------------------------
  // counts 2*(rate+1) steps, reloads on expiry
  // ----------------------------------------------------------------
  logic [16:0] cnt_reg;
  logic [16:0] last;
  assign last = {rate, 1'b1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 17'h00000;
      expire <= 1'b0;
      half_tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 17'h00000;
      expire <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      expire <= 1'b0;
      half_tick <= 1'b0;
      if (step) begin
        half_tick <= 1'b1;
        if (cnt_reg >= last) begin
          cnt_reg <= 17'h00000;
          expire <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 17'h00001;
        end
      end
    end
  end
endmodule : period_counter

// >>> hw/periodic_wakeup_timer.sv
`timescale 1ns/100ps
module periodic_wakeup_timer
  import wakeup_timer_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic analog_supply_low,
  input wire logic trim_load_valid,
  input wire logic [5:0] trim_load_value,
  output logic periodic_wave_pin,
  output logic supply_low_irq,
  output logic periodic_irq,
  output logic irq
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic known_addr;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known_addr;

  always_comb begin
    if (paddr == ADDR_LV_CTRL) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_PT_CTRL) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_TRIM) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_RATE_HI) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_RATE_LO) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_IRQ_STATUS) begin
      known_addr = 1'b1;
    end else if (paddr == ADDR_IRQ_MASK) begin
      known_addr = 1'b1;
    end else begin
      known_addr = 1'b0;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  // ----------------------------------------------------------------
  // supply status synchroniser
  // ----------------------------------------------------------------
  logic supply_meta_reg;
  logic supply_status_reg;
  logic supply_prev_reg;
  logic supply_change;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_meta_reg <= 1'b0;
      supply_status_reg <= 1'b0;
      supply_prev_reg <= 1'b0;
    end else begin
      supply_meta_reg <= analog_supply_low;
      supply_status_reg <= supply_meta_reg;
      supply_prev_reg <= supply_status_reg;
    end
  end
  assign supply_change = supply_status_reg ^ supply_prev_reg;

  // ----------------------------------------------------------------
  // supply low control
  // ----------------------------------------------------------------
  logic supply_low_irq_enable_reg;
  logic supply_low_flag_reg;
  logic clr_lv;
  logic clr_pt;

  assign clr_lv = wr_en && ((hit(paddr, ADDR_LV_CTRL) && pwdata[LV_FLAG_BIT]) ||
                            (hit(paddr, ADDR_IRQ_STATUS) && pwdata[IRQ_LV_BIT]));
  assign clr_pt = wr_en && ((hit(paddr, ADDR_PT_CTRL) && pwdata[PT_FLAG_BIT]) ||
                            (hit(paddr, ADDR_IRQ_STATUS) && pwdata[IRQ_PT_BIT]));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_low_irq_enable_reg <= 1'b0;
    end else if (wr_en && hit(paddr, ADDR_LV_CTRL)) begin
      supply_low_irq_enable_reg <= pwdata[LV_IE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_low_flag_reg <= 1'b0;
    end else if (supply_change) begin
      supply_low_flag_reg <= 1'b1;
    end else if (clr_lv) begin
      supply_low_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // periodic timer control
  // ----------------------------------------------------------------
  logic periodic_clock_select_reg;
  logic pin_waveform_select_reg;
  logic pin_output_enable_reg;
  logic periodic_feature_enable_reg;
  logic periodic_irq_enable_reg;
  logic periodic_timeout_flag_reg;
  logic [15:0] period_rate_value_reg;
  logic [5:0] slow_osc_trim_value_reg;
  logic [1:0] irq_mask_reg;
  logic pt_wr;

  assign pt_wr = wr_en && hit(paddr, ADDR_PT_CTRL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_clock_select_reg <= 1'b0;
      pin_waveform_select_reg <= 1'b0;
      pin_output_enable_reg <= 1'b0;
      periodic_feature_enable_reg <= 1'b0;
      periodic_irq_enable_reg <= 1'b0;
    end else if (pt_wr) begin
      if (!periodic_feature_enable_reg && !pwdata[PT_FE_BIT]) begin
        periodic_clock_select_reg <= pwdata[PT_CLKSEL_BIT];
      end
      pin_waveform_select_reg <= pwdata[PT_WAVESEL_BIT];
      pin_output_enable_reg <= pwdata[PT_PINEN_BIT];
      periodic_feature_enable_reg <= pwdata[PT_FE_BIT];
      periodic_irq_enable_reg <= pwdata[PT_IE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_rate_value_reg <= RATE_RESET;
    end else if (wr_en && !periodic_feature_enable_reg) begin
      if (hit(paddr, ADDR_RATE_HI)) begin
        period_rate_value_reg[15:8] <= pwdata[7:0];
      end else if (hit(paddr, ADDR_RATE_LO)) begin
        period_rate_value_reg[7:0] <= pwdata[7:0];
      end
    end
  end

  // trim: flash load after reset release wins over software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_osc_trim_value_reg <= TRIM_RESET;
    end else if (trim_load_valid) begin
      slow_osc_trim_value_reg <= trim_load_value;
    end else if (wr_en && hit(paddr, ADDR_TRIM)) begin
      slow_osc_trim_value_reg <= pwdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (wr_en && hit(paddr, ADDR_IRQ_MASK)) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // timebase and counter
  // ----------------------------------------------------------------
  logic slow_tick;
  logic gate_meta_reg;
  logic gate_reg;
  logic step;
  logic half_tick;
  logic expire;

  // gate release on slow ticks: first period runs 2 ticks longer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_meta_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else if (!periodic_feature_enable_reg) begin
      gate_meta_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else if (slow_tick) begin
      gate_meta_reg <= 1'b1;
      gate_reg <= gate_meta_reg;
    end
  end

  slow_tick_gen #(
    .DIV(SLOW_DIV)
  ) u_slow (
    .clk(clk),
    .rst_n(rst_n),
    .run(periodic_feature_enable_reg),
    .trim(slow_osc_trim_value_reg),
    .tick(slow_tick)
  );

  // slow mode steps every second slow tick, i.e. ACLK*2
  logic slow_half_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_half_reg <= 1'b0;
    end else if (!gate_reg) begin
      slow_half_reg <= 1'b0;
    end else if (slow_tick) begin
      slow_half_reg <= !slow_half_reg;
    end
  end

  always_comb begin
    if (periodic_clock_select_reg) begin
      step = periodic_feature_enable_reg;
    end else begin
      step = gate_reg && slow_tick && slow_half_reg;
    end
  end

  period_counter u_count (
    .clk(clk),
    .rst_n(rst_n),
    .run(periodic_feature_enable_reg),
    .step(step),
    .rate(period_rate_value_reg),
    .half_tick(half_tick),
    .expire(expire)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_timeout_flag_reg <= 1'b0;
    end else if (expire) begin
      periodic_timeout_flag_reg <= 1'b1;
    end else if (clr_pt) begin
      periodic_timeout_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // external waveform
  // ----------------------------------------------------------------
  logic pulse_reg;
  logic square_reg;
  logic [1:0] pulse_cnt_reg;

  // pulse lasts one timer step, half the minimum period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
      pulse_cnt_reg <= 2'h0;
    end else if (expire) begin
      pulse_reg <= 1'b1;
      pulse_cnt_reg <= 2'(PULSE_TICKS);
    end else if (half_tick && pulse_cnt_reg != 2'h0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 2'h1;
      if (pulse_cnt_reg == 2'h1) begin
        pulse_reg <= 1'b0;
      end
    end else if (!periodic_feature_enable_reg) begin
      pulse_reg <= 1'b0;
      pulse_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      square_reg <= 1'b0;
    end else if (!periodic_feature_enable_reg) begin
      square_reg <= 1'b0;
    end else if (expire) begin
      square_reg <= !square_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_wave_pin <= 1'b0;
    end else if (pin_output_enable_reg && periodic_feature_enable_reg) begin
      periodic_wave_pin <= pin_waveform_select_reg ? square_reg : pulse_reg;
    end else begin
      periodic_wave_pin <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign supply_low_irq = supply_low_flag_reg && supply_low_irq_enable_reg;
  assign periodic_irq = periodic_timeout_flag_reg && periodic_irq_enable_reg;
  assign irq = |({periodic_timeout_flag_reg, supply_low_flag_reg} & irq_mask_reg);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, ADDR_LV_CTRL)) begin
        prdata <= {29'h0, supply_status_reg, supply_low_irq_enable_reg,
                   supply_low_flag_reg};
      end else if (hit(paddr, ADDR_PT_CTRL)) begin
        prdata <= {24'h0, periodic_clock_select_reg, 2'h0, pin_waveform_select_reg,
                   pin_output_enable_reg, periodic_feature_enable_reg,
                   periodic_irq_enable_reg, periodic_timeout_flag_reg};
      end else if (hit(paddr, ADDR_TRIM)) begin
        prdata <= {26'h0, slow_osc_trim_value_reg};
      end else if (hit(paddr, ADDR_RATE_HI)) begin
        prdata <= {24'h0, period_rate_value_reg[15:8]};
      end else if (hit(paddr, ADDR_RATE_LO)) begin
        prdata <= {24'h0, period_rate_value_reg[7:0]};
      end else if (hit(paddr, ADDR_IRQ_STATUS)) begin
        prdata <= {30'h0, periodic_timeout_flag_reg, supply_low_flag_reg};
      end else if (hit(paddr, ADDR_IRQ_MASK)) begin
        prdata <= {30'h0, irq_mask_reg};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : periodic_wakeup_timer

// >>> tb/periodic_wakeup_timer_assertions.sv
`timescale 1ns/100ps
module periodic_wakeup_timer_assertions
  import wakeup_timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic analog_supply_low,
  input wire logic trim_load_valid,
  input wire logic [5:0] trim_load_value,
  input wire logic periodic_wave_pin,
  input wire logic supply_low_irq,
  input wire logic periodic_irq,
  input wire logic irq
);
  // ------
  // shadow of written control bits
  // ------
  logic fe_s, pe_s, ws_s, ie_s, cs_s, lie_s;
  logic [1:0] mk_s;
  wire wr = psel && penable && pwrite && pready;
  wire wr_pt = wr && (paddr == ADDR_PT_CTRL);
  wire wr_lv = wr && (paddr == ADDR_LV_CTRL);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {fe_s, pe_s, ws_s, ie_s, cs_s, lie_s} <= 6'h00;
      mk_s <= 2'h0;
    end else begin
      if (wr_pt) begin
        fe_s <= pwdata[PT_FE_BIT];
        pe_s <= pwdata[PT_PINEN_BIT];
        ws_s <= pwdata[PT_WAVESEL_BIT];
        ie_s <= pwdata[PT_IE_BIT];
        if (!fe_s && !pwdata[PT_FE_BIT]) begin
          cs_s <= pwdata[PT_CLKSEL_BIT];
        end
      end
      if (wr_lv) begin
        lie_s <= pwdata[LV_IE_BIT];
      end
      if (wr && (paddr == ADDR_IRQ_MASK)) begin
        mk_s <= pwdata[1:0];
      end
    end
  end
  // ------
  // properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pin_off; (!(fe_s && pe_s)) [*3] |-> !periodic_wave_pin; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");
  property p_pt_ie; !ie_s |-> !periodic_irq; endproperty
  a_pt_ie: assert property (p_pt_ie) else $error("timer irq while disabled");
  property p_lv_ie; !lie_s |-> !supply_low_irq; endproperty
  a_lv_ie: assert property (p_lv_ie) else $error("supply irq while disabled");
  property p_mask; mk_s == 2'h0 |-> !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq while all masked");
  property p_pt_keep;
    wr_pt && !pwdata[PT_FLAG_BIT] && pwdata[PT_IE_BIT] && periodic_irq |=> periodic_irq;
  endproperty
  a_pt_keep: assert property (p_pt_keep) else $error("timer flag lost on zero");
  property p_pt_clr;
    wr_pt && pwdata[PT_FLAG_BIT] && pwdata[PT_IE_BIT] && !pwdata[PT_FE_BIT] && !fe_s
      |=> !periodic_irq;
  endproperty
  a_pt_clr: assert property (p_pt_clr) else $error("timer flag not cleared");
  property p_lv_keep;
    wr_lv && !pwdata[LV_FLAG_BIT] && pwdata[LV_IE_BIT] && supply_low_irq |=> supply_low_irq;
  endproperty
  a_lv_keep: assert property (p_lv_keep) else $error("supply flag lost on zero");
  property p_lv_set; $changed(analog_supply_low) && lie_s |-> ##[1:5] supply_low_irq; endproperty
  a_lv_set: assert property (p_lv_set) else $error("supply change not flagged");
  property p_pulse;
    $rose(periodic_wave_pin) && !ws_s && cs_s && fe_s |-> ##[1:2] !periodic_wave_pin;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too wide");
  property p_wave; $rose(periodic_wave_pin) && ws_s && cs_s |=> periodic_wave_pin; endproperty
  a_wave: assert property (p_wave) else $error("wave high too short");
  c_pt: cover property ($rose(periodic_irq));
  c_lv: cover property ($rose(supply_low_irq));
  c_pin: cover property ($rose(periodic_wave_pin) && ws_s);
endmodule : periodic_wakeup_timer_assertions

bind periodic_wakeup_timer periodic_wakeup_timer_assertions i_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_supply_low(analog_supply_low), .trim_load_valid(trim_load_valid),
  .trim_load_value(trim_load_value), .periodic_wave_pin(periodic_wave_pin),
  .supply_low_irq(supply_low_irq), .periodic_irq(periodic_irq), .irq(irq)
);

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  import wakeup_timer_pkg::*;
  localparam int SD = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, trim_load_valid = 1'b0, analog_supply_low = 1'b0;
  logic [5:0] trim_load_value = 6'h00;
  logic periodic_wave_pin, supply_low_irq, periodic_irq, irq;
  logic [7:0] ra [6] = '{ADDR_LV_CTRL, ADDR_PT_CTRL, ADDR_TRIM, ADDR_RATE_HI, ADDR_RATE_LO,
    ADDR_IRQ_MASK};
  int errors = 0, n_tests = 0, w;
  integer seed = 32'hCFB0;
  always #4 clk = ~clk;
  periodic_wakeup_timer #(.SLOW_DIV(SD)) i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_supply_low(analog_supply_low), .trim_load_valid(trim_load_valid),
    .trim_load_value(trim_load_value), .periodic_wave_pin(periodic_wave_pin),
    .supply_low_irq(supply_low_irq), .periodic_irq(periodic_irq), .irq(irq)
  );
  // ------
  // bench tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("read", rd, exp);
  endtask : rdc
  task automatic wrise(output int n);
    logic pv;
    for (n = 1; n < 3000; n++) begin
      pv = periodic_wave_pin;
      @(posedge clk);
      #1;
      if (pv === 1'b0 && periodic_wave_pin === 1'b1) break;
    end
  endtask : wrise
  // pin period and width for one setting
  task automatic mode(input logic cs, input logic ws, input logic [15:0] r, input logic [5:0] tr);
    int g, st, t;
    t = $signed(tr);
    st = SD - (t >>> 2);
    if (st < 4) st = 4;
    st = cs ? 1 : 2 * st;
    apb(1'b1, ADDR_PT_CTRL, 32'h0);
    apb(1'b1, ADDR_PT_CTRL, 32'({cs, 7'h0}));
    apb(1'b1, ADDR_RATE_HI, 32'(r[15:8]));
    apb(1'b1, ADDR_RATE_LO, 32'(r[7:0]));
    apb(1'b1, ADDR_TRIM, 32'(tr));
    rdc(ADDR_TRIM, 32'(tr));
    apb(1'b1, ADDR_PT_CTRL, 32'({cs, 2'b00, ws, 4'b1100}));
    wrise(g);
    wrise(g);
    w = 0;
    while (periodic_wave_pin === 1'b1 && w < 3000) begin
      @(posedge clk);
      #1;
      w++;
    end
    chk("gap", g, 32'((ws ? 4 : 2) * (r + 1) * st));
    chk("width", w, 32'(ws ? 2 * (r + 1) * st : st));
  endtask : mode
  // ------
  // main sequence
  // ------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rdc(ra[i], 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", se, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    @(posedge clk);
    trim_load_value <= 6'h2A;
    trim_load_valid <= 1'b1;
    @(posedge clk);
    trim_load_valid <= 1'b0;
    @(posedge clk);
    rdc(ADDR_TRIM, 32'h2A);
    apb(1'b1, ADDR_LV_CTRL, 32'h2);
    @(posedge clk);
    analog_supply_low <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(ADDR_LV_CTRL, 32'h7);
    chk("lv_irq", supply_low_irq, 1'b1);
    apb(1'b1, ADDR_LV_CTRL, 32'h6);
    rdc(ADDR_LV_CTRL, 32'h7);
    apb(1'b1, ADDR_LV_CTRL, 32'h3);
    rdc(ADDR_LV_CTRL, 32'h6);
    apb(1'b1, ADDR_LV_CTRL, 32'h0);
    @(posedge clk);
    analog_supply_low <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(ADDR_LV_CTRL, 32'h1);
    chk("lv_irq", supply_low_irq, 1'b0);
    rdc(ADDR_IRQ_STATUS, 32'h1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h3);
    chk("irq", irq, 1'b1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
    rdc(ADDR_LV_CTRL, 32'h0);
    chk("irq", irq, 1'b0);
    apb(1'b1, ADDR_RATE_LO, 32'h3);
    apb(1'b1, ADDR_PT_CTRL, 32'h80);
    apb(1'b1, ADDR_PT_CTRL, 32'h86);
    repeat (12) @(posedge clk);
    #1;
    chk("pt_irq", periodic_irq, 1'b1);
    apb(1'b1, ADDR_RATE_LO, 32'h9);
    rdc(ADDR_RATE_LO, 32'h3);
    apb(1'b1, ADDR_PT_CTRL, 32'h4);
    apb(1'b1, ADDR_PT_CTRL, 32'h82);
    apb(1'b1, ADDR_PT_CTRL, 32'h83);
    chk("pt_irq", periodic_irq, 1'b0);
    apb(1'b1, ADDR_PT_CTRL, 32'h04);
    repeat (12) @(posedge clk);
    #1;
    chk("pt_irq", periodic_irq, 1'b0);
    apb(1'b0, ADDR_PT_CTRL, 32'h0);
    chk("ctrl", rd[7:0] & 8'h85, 8'h85);
    chk("irq", irq, 1'b1);
    apb(1'b1, ADDR_PT_CTRL, 32'h94);
    w = 0;
    repeat (100) begin
      @(posedge clk);
      w += periodic_wave_pin;
    end
    chk("pin_off", w, 32'h0);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h3);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    mode(1'b1, 1'b0, 16'h0, 6'h00);
    mode(1'b1, 1'b1, 16'h0, 6'h00);
    mode(1'b1, 1'b0, 16'h1, 6'h00);
    mode(0, 1, 16'h1, 6'h00);
    mode(0, 0, 16'h0, 6'h08);
    mode(0, 1, 16'h0, 6'h38);
    repeat (4) mode(1'b1, 1'($random(seed)), 16'($random(seed)) & 16'h000F, 6'h00);
    repeat (2) mode(1'b0, 1'($random(seed)), 16'h1, 6'($random(seed)));
    test_done();
  end
  initial begin
    #(8 * 60000);
    errors++;
    test_done();
  end
endmodule : tb
